/* File: logic/lbft_core.sv */
`include "lbft_defs.svh"

module lbft_core
    import lbft_pkg::*;
#(
    parameter int TB_PER_TICK = `LBFT_TB_PER_TICK
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             err_o,
    input  wire logic        sync_pin_i,
    input  wire logic        flash_trigger_i,
    output logic [2:0]       color_out_o,
    output lbft_flash_out_t  flash_o
);
    logic [7:0]      red_blink_times_r;
    logic [7:0]      red_blink_cycle_r;
    logic [7:0]      green_blink_times_r;
    logic [7:0]      green_blink_cycle_r;
    logic [7:0]      blue_blink_times_r;
    logic [7:0]      blue_blink_cycle_r;
    logic [7:0]      flash_control_r;
    logic [7:0]      sequencer_control_r;
    logic [7:0]      output_control_r;
    logic [31:0]     rdata_nxt;
    logic            hit;
    logic            req;
    logic            wr;
    logic            tick;
    logic            run;
    logic [2:0]      blink;
    logic [7:0]      times   [3];
    logic [7:0]      cycles  [3];
    lbft_flash_st_t  fl_st_r;
    lbft_flash_st_t  fl_st_nxt;
    logic [10:0]     fl_cnt_r;
    logic [10:0]     fl_limit;
    logic            trig1_r;
    logic            trig2_r;
    logic            trig3_r;
    logic            trig_rise;
    logic            fl_en;
    logic            fl_en_prev_r;
    logic            safety_trip;
    logic [1:0]      fl_dur;

    assign req = cyc_i & stb_i;
    assign wr  = req & we_i & ~ack_o & sel_i[0];

    function automatic logic reg_hit(input logic [5:0] idx);
        unique case (idx)
            `LBFT_IDX_RED_TIMES, `LBFT_IDX_RED_CYCLE,
            `LBFT_IDX_GREEN_TIMES, `LBFT_IDX_GREEN_CYCLE,
            `LBFT_IDX_BLUE_TIMES, `LBFT_IDX_BLUE_CYCLE,
            `LBFT_IDX_FLASH_CTRL, `LBFT_IDX_SEQ_CTRL,
            `LBFT_IDX_OUT_CTRL, `LBFT_IDX_STATUS: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction

    assign hit = reg_hit(adr_i[7:2]) && (adr_i[1:0] == 2'h0);

    // One wait-free cycle: ack or err in the cycle after the request.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_o <= req & hit & ~ack_o & ~err_o;
            err_o <= req & ~hit & ~ack_o & ~err_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            red_blink_times_r   <= `LBFT_RESET_CTRL;
            red_blink_cycle_r   <= `LBFT_RESET_CTRL;
            green_blink_times_r <= `LBFT_RESET_CTRL;
            green_blink_cycle_r <= `LBFT_RESET_CTRL;
            blue_blink_times_r  <= `LBFT_RESET_CTRL;
            blue_blink_cycle_r  <= `LBFT_RESET_CTRL;
            flash_control_r     <= `LBFT_RESET_CTRL;
            sequencer_control_r <= `LBFT_RESET_CTRL;
            output_control_r    <= `LBFT_RESET_CTRL;
        end else if (wr && hit) begin
            unique case (adr_i[7:2])
                `LBFT_IDX_RED_TIMES:   red_blink_times_r   <= dat_i[7:0];
                `LBFT_IDX_RED_CYCLE:   red_blink_cycle_r   <= dat_i[7:0];
                `LBFT_IDX_GREEN_TIMES: green_blink_times_r <= dat_i[7:0];
                `LBFT_IDX_GREEN_CYCLE: green_blink_cycle_r <= dat_i[7:0];
                `LBFT_IDX_BLUE_TIMES:  blue_blink_times_r  <= dat_i[7:0];
                `LBFT_IDX_BLUE_CYCLE:  blue_blink_cycle_r  <= dat_i[7:0];
                `LBFT_IDX_FLASH_CTRL:  flash_control_r     <= dat_i[7:0];
                `LBFT_IDX_SEQ_CTRL:    sequencer_control_r <= dat_i[7:0];
                `LBFT_IDX_OUT_CTRL:    output_control_r    <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (adr_i[7:2])
            `LBFT_IDX_RED_TIMES:   rdata_nxt[7:0] = red_blink_times_r;
            `LBFT_IDX_RED_CYCLE:   rdata_nxt[7:0] = red_blink_cycle_r;
            `LBFT_IDX_GREEN_TIMES: rdata_nxt[7:0] = green_blink_times_r;
            `LBFT_IDX_GREEN_CYCLE: rdata_nxt[7:0] = green_blink_cycle_r;
            `LBFT_IDX_BLUE_TIMES:  rdata_nxt[7:0] = blue_blink_times_r;
            `LBFT_IDX_BLUE_CYCLE:  rdata_nxt[7:0] = blue_blink_cycle_r;
            `LBFT_IDX_FLASH_CTRL:  rdata_nxt[7:0] = flash_control_r;
            `LBFT_IDX_SEQ_CTRL:    rdata_nxt[7:0] = sequencer_control_r;
            `LBFT_IDX_OUT_CTRL:    rdata_nxt[7:0] = output_control_r;
            `LBFT_IDX_STATUS:      rdata_nxt[7:0] = {fl_st_r, 1'b0, blink};
            default: ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i && !ack_o) begin
            dat_o <= rdata_nxt;
        end
    end

    lbft_timebase #(
        .TB_PER_TICK (TB_PER_TICK)
    ) u_timebase (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ext_sel_i  (output_control_r[`LBFT_OC_EXTSYNC_BIT]),
        .sync_pin_i (sync_pin_i),
        .tick_o     (tick)
    );

    // Enabled channels restart together once the start bit and the blink output select are both set.
    assign run = sequencer_control_r[`LBFT_SEQ_START_BIT] &&
                 (output_control_r[`LBFT_OC_SEL_LSB +: 2] ==
                  `LBFT_SEL_BLINK);

    assign times[0]  = red_blink_times_r;
    assign times[1]  = green_blink_times_r;
    assign times[2]  = blue_blink_times_r;
    assign cycles[0] = red_blink_cycle_r;
    assign cycles[1] = green_blink_cycle_r;
    assign cycles[2] = blue_blink_cycle_r;

    for (genvar ch = 0; ch < 3; ch++) begin : g_chan
        lbft_chan_cfg_t cfg;
        assign cfg.on_code  = times[ch][7:4];
        assign cfg.off_code = times[ch][3:0];
        assign cfg.enable   = cycles[ch][`LBFT_CYC_EN_BIT];
        assign cfg.period   = cycles[ch][2:0];

        lbft_blink_chan u_chan (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .tick_i  (tick),
            .run_i   (run && cfg.enable),
            .cfg_i   (cfg),
            .blink_o (blink[ch])
        );

        // Without blinking the switch bit alone sets the output.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                color_out_o[ch] <= 1'b0;
            end else begin
                color_out_o[ch] <= output_control_r[`LBFT_OC_SW_LSB + ch] &&
                                   (!(run && cfg.enable) || blink[ch]);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig1_r <= 1'b0;
            trig2_r <= 1'b0;
            trig3_r <= 1'b0;
        end else begin
            trig1_r <= flash_trigger_i;
            trig2_r <= trig1_r;
            trig3_r <= trig2_r;
        end
    end

    assign trig_rise = trig2_r & ~trig3_r;
    assign fl_en     = flash_control_r[`LBFT_FL_EN_BIT];
    assign fl_dur    = flash_control_r[`LBFT_FL_DUR_LSB +: 2];

    always_comb begin
        unique case (fl_dur)
            2'h0: fl_limit = 11'(`LBFT_FLASH1_MS);
            2'h1: fl_limit = 11'(`LBFT_FLASH2_MS);
            2'h2: fl_limit = 11'(`LBFT_FLASH3_MS);
            2'h3: fl_limit = 11'(`LBFT_SAFETY_MS);
        endcase
    end

    assign safety_trip = (fl_dur == `LBFT_DUR_FOLLOW) &&
                         flash_control_r[`LBFT_FL_SAFETY_BIT] &&
                         (fl_cnt_r >= fl_limit);

    always_comb begin
        fl_st_nxt = fl_st_r;
        unique case (fl_st_r)
            LBFT_FL_OFF: begin
                if (fl_en && !fl_en_prev_r) begin
                    fl_st_nxt = LBFT_FL_VIEW;
                end
            end
            LBFT_FL_VIEW: begin
                if (!fl_en) begin
                    fl_st_nxt = LBFT_FL_OFF;
                end else if (trig_rise) begin
                    fl_st_nxt = LBFT_FL_FIRE;
                end
            end
            LBFT_FL_FIRE: begin
                if (!fl_en) begin
                    fl_st_nxt = LBFT_FL_OFF;
                end else if (fl_dur == `LBFT_DUR_FOLLOW) begin
                    if (!trig2_r || safety_trip) begin
                        fl_st_nxt = LBFT_FL_SPENT;
                    end
                end else if (fl_cnt_r >= fl_limit) begin
                    fl_st_nxt = LBFT_FL_SPENT;
                end
            end
            LBFT_FL_SPENT: begin
                if (!fl_en) begin
                    fl_st_nxt = LBFT_FL_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fl_st_r      <= LBFT_FL_OFF;
            fl_en_prev_r <= 1'b0;
        end else begin
            fl_st_r      <= fl_st_nxt;
            fl_en_prev_r <= fl_en;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || fl_st_r != LBFT_FL_FIRE) begin
            fl_cnt_r <= 11'h000;
        end else if (tick && fl_cnt_r != 11'h7ff) begin
            fl_cnt_r <= fl_cnt_r + 11'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_o <= '0;
        end else begin
            flash_o.on     <= (fl_st_nxt == LBFT_FL_VIEW) ||
                              (fl_st_nxt == LBFT_FL_FIRE);
            flash_o.full   <= (fl_st_nxt == LBFT_FL_FIRE);
            flash_o.level  <= (fl_st_nxt == LBFT_FL_FIRE) ? 2'h3 :
                              flash_control_r[`LBFT_FL_CUR_LSB +: 2];
            flash_o.pwm_en <= flash_control_r[`LBFT_FL_PWM_BIT];
        end
    end
endmodule // lbft_core

/* File: shared/lbft_defs.svh */
`ifndef LBFT_DEFS_SVH
`define LBFT_DEFS_SVH

// Register indexes; byte address is four times the index.
`define LBFT_IDX_RED_TIMES     6'h01
`define LBFT_IDX_RED_CYCLE     6'h02
`define LBFT_IDX_GREEN_TIMES   6'h03
`define LBFT_IDX_GREEN_CYCLE   6'h04
`define LBFT_IDX_BLUE_TIMES    6'h05
`define LBFT_IDX_BLUE_CYCLE    6'h06
`define LBFT_IDX_FLASH_CTRL    6'h10
`define LBFT_IDX_SEQ_CTRL      6'h11
`define LBFT_IDX_OUT_CTRL      6'h12
`define LBFT_IDX_STATUS        6'h13

// Cycle register fields.
`define LBFT_CYC_EN_BIT        3
// Sequencer control fields.
`define LBFT_SEQ_START_BIT     3
// Flash control fields.
`define LBFT_FL_EN_BIT         0
`define LBFT_FL_SAFETY_BIT     1
`define LBFT_FL_DUR_LSB        2
`define LBFT_FL_CUR_LSB        6
`define LBFT_FL_PWM_BIT        5
// Output control fields (own register).
`define LBFT_OC_SW_LSB         0
`define LBFT_OC_SEL_LSB        3
`define LBFT_OC_EXTSYNC_BIT    5

`define LBFT_SEL_BLINK         2'h1
`define LBFT_DUR_FOLLOW        2'h3

// Timing: internal timebase 5 MHz, blink/flash resolution 1 ms.
`define LBFT_TB_HZ             5000000
`define LBFT_CLK_HZ            10000000
`define LBFT_TICK_US           1000
`define LBFT_INT_DIV           ((`LBFT_CLK_HZ / `LBFT_TB_HZ))
`define LBFT_TB_PER_TICK       ((`LBFT_TB_HZ / 1000000) * `LBFT_TICK_US)
`define LBFT_FLASH1_MS         200
`define LBFT_FLASH2_MS         400
`define LBFT_FLASH3_MS         600
`define LBFT_SAFETY_MS         1200
`define LBFT_RESET_CTRL        8'h00

`endif

/* File: shared/lbft_pkg.sv */
package lbft_pkg;
    typedef struct packed {
        logic [3:0] on_code;
        logic [3:0] off_code;
        logic       enable;
        logic [2:0] period;
    } lbft_chan_cfg_t;

    typedef struct packed {
        logic [1:0] level;
        logic       on;
        logic       full;
        logic       pwm_en;
    } lbft_flash_out_t;

    typedef enum logic [3:0] {
        LBFT_FL_OFF   = 4'b0001,
        LBFT_FL_VIEW  = 4'b0010,
        LBFT_FL_FIRE  = 4'b0100,
        LBFT_FL_SPENT = 4'b1000
    } lbft_flash_st_t;
endpackage

/* File: logic/lbft_timebase.sv */
`include "lbft_defs.svh"

// Selects internal or external timebase and produces a 1 ms tick pulse.
module lbft_timebase
    import lbft_pkg::*;
#(
    parameter int TB_PER_TICK = `LBFT_TB_PER_TICK
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ext_sel_i,
    input  wire logic sync_pin_i,
    output logic      tick_o
);
    logic        s1_r;
    logic        s2_r;
    logic        s3_r;
    logic        int_r;
    logic        tb_edge;
    logic [15:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= sync_pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Internal 5 MHz is half the system clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_r <= 1'b0;
        end else begin
            int_r <= ~int_r;
        end
    end

    // An external clock near 5 MHz is undersampled; its rate sets timing.
    assign tb_edge = ext_sel_i ? (s2_r & ~s3_r) : int_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 16'h0000;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (tb_edge) begin
                if (cnt_r == 16'(TB_PER_TICK - 1)) begin
                    cnt_r  <= 16'h0000;
                    tick_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 16'h0001;
                end
            end
        end
    end
endmodule // lbft_timebase

/* File: logic/lbft_blink_chan.sv */
`include "lbft_defs.svh"

// One colour channel blink generator, counting 1 ms ticks.
module lbft_blink_chan
    import lbft_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           tick_i,
    input  wire logic           run_i,
    input  wire lbft_chan_cfg_t cfg_i,
    output logic                blink_o
);
    logic [12:0] pos_r;
    logic [12:0] period;
    logic [12:0] off_t;
    logic [12:0] on_t;
    logic [13:0] on_end;

    function automatic logic [9:0] share_pm(input logic [3:0] c);
        unique case (c)
            4'h0: share_pm = 10'd0;
            4'h1: share_pm = 10'd10;
            4'h2: share_pm = 10'd25;
            4'h3: share_pm = 10'd50;
            4'h4: share_pm = 10'd75;
            4'h5: share_pm = 10'd100;
            4'h6: share_pm = 10'd150;
            4'h7: share_pm = 10'd200;
            4'h8: share_pm = 10'd300;
            4'h9: share_pm = 10'd400;
            4'ha: share_pm = 10'd500;
            4'hb: share_pm = 10'd600;
            4'hc: share_pm = 10'd700;
            4'hd: share_pm = 10'd800;
            4'he: share_pm = 10'd900;
            4'hf: share_pm = 10'd1000;
        endcase
    endfunction

    // Period in ticks. Shares truncate to whole ticks, so the 100, 250 and 500 ms
    // periods lose up to one tick per window.
    function automatic logic [12:0] period_ms(input logic [2:0] c);
        unique case (c)
            3'h0: period_ms = 13'd100;
            3'h1: period_ms = 13'd250;
            3'h2: period_ms = 13'd500;
            3'h3: period_ms = 13'd1000;
            3'h4: period_ms = 13'd2000;
            3'h5: period_ms = 13'd3000;
            3'h6: period_ms = 13'd4000;
            3'h7: period_ms = 13'd5000;
        endcase
    endfunction

    function automatic logic [12:0] scale(input logic [12:0] p,
                                          input logic [9:0]  pm);
        logic [22:0] prod;
        prod  = 23'(p) * 23'(pm);
        scale = 13'(prod / 23'd1000);
    endfunction

    assign period = period_ms(cfg_i.period);
    assign off_t  = scale(period, share_pm(cfg_i.off_code));
    assign on_t   = scale(period, share_pm(cfg_i.on_code));
    // ON window is cut at the period end while OFF keeps its length.
    assign on_end = (14'(off_t) + 14'(on_t) > 14'(period)) ?
                    14'(period) : 14'(off_t) + 14'(on_t);

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            pos_r <= 13'h0000;
        end else if (tick_i) begin
            if (pos_r >= period - 13'd1) begin
                pos_r <= 13'h0000;
            end else begin
                pos_r <= pos_r + 13'd1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_o <= 1'b0;
        end else begin
            blink_o <= run_i && (pos_r >= off_t) &&
                       (14'(pos_r) < on_end);
        end
    end
endmodule // lbft_blink_chan

/* File: verif/lbft_core_chk.sv */
module lbft_core_chk
    import lbft_pkg::*;
(
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            cyc_i,
    input wire logic            stb_i,
    input wire logic            we_i,
    input wire logic [7:0]      adr_i,
    input wire logic [3:0]      sel_i,
    input wire logic [31:0]     dat_i,
    input wire logic [31:0]     dat_o,
    input wire logic            ack_o,
    input wire logic            err_o,
    input wire logic            flash_trigger_i,
    input wire lbft_flash_out_t flash_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic spent_r;
    logic clr_w;
    assign clr_w = cyc_i && stb_i && we_i && sel_i[0] &&
                   adr_i == 8'h40 && !dat_i[0];
    // Cleared only by a write of zero to the flash enable bit.
    // A flash cut short by that write leaves nothing to re-arm.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spent_r <= 1'b0;
        end else if ($fell(flash_o.full) && !$past(clr_w)) begin
            spent_r <= 1'b1;
        end else if (clr_w) begin
            spent_r <= 1'b0;
        end
    end
    sequence take_s;
        cyc_i && stb_i && !ack_o && !err_o;
    endsequence
    sequence answer_s;
        (ack_o ^ err_o) ##1 !(ack_o || err_o);
    endsequence
    bus_answer_a: assert property (take_s |=> answer_s)
        else $error("bus answer missing or too long");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    err_cause_a: assert property (err_o |-> $past(cyc_i && stb_i))
        else $error("err without request");
    read_upper_a: assert property (ack_o && !$past(we_i) |->
        dat_o[31:8] == 24'h0) else $error("read data upper bits set");
    fire_cause_a: assert property ($rose(flash_o.full) |->
        $past(flash_trigger_i, 2)) else $error("flash without trigger");
    full_on_a: assert property (flash_o.full |-> flash_o.on)
        else $error("full current with output off");
    full_level_a: assert property (flash_o.full |->
        flash_o.level == 2'h3) else $error("flash below maximum current");
    spent_off_a: assert property ($fell(flash_o.full) |-> !flash_o.on)
        else $error("output left on after flash");
    no_refire_a: assert property (spent_r |-> !$rose(flash_o.full))
        else $error("flash again without re-arming");
endmodule // lbft_core_chk

bind lbft_core lbft_core_chk i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .flash_trigger_i(flash_trigger_i), .flash_o(flash_o)
);

/* File: verif/lbft_pins_model.sv */
module lbft_pins_model (
    input  wire logic        clk_i,
    input  wire logic        sync_run_i,
    input  wire logic        trig_go_i,
    input  wire logic [15:0] trig_len_i,
    output logic             sync_pin_o,
    output logic             trig_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] left_r = 16'h0;
    // Period 874 ns keeps the sync clock out of phase with the system clock.
    initial begin
        sync_pin_o = 1'b0;
        forever begin
            #437;
            sync_pin_o = sync_run_i ? ~sync_pin_o : 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (trig_go_i) begin
            left_r <= trig_len_i;
        end else if (left_r != 16'h0) begin
            left_r <= left_r - 16'h1;
        end
    end
    assign trig_o = left_r != 16'h0;
endmodule // lbft_pins_model

/* File: verif/led_blink_and_flash_timing_test.sv */
`include "lbft_defs.svh"
module led_blink_and_flash_timing_test
    import lbft_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic            clk_i;
    logic            rst_i = 1'b1;
    logic            cyc_i = 1'b0;
    logic            stb_i = 1'b0;
    logic            we_i = 1'b0;
    logic [7:0]      adr_i = 8'h00;
    logic [3:0]      sel_i = 4'h0;
    logic [31:0]     dat_i = 32'h0;
    logic [31:0]     dat_o;
    logic            ack_o;
    logic            err_o;
    logic            sync_pin_i;
    logic            flash_trigger_i;
    logic            sync_run = 1'b0;
    logic            trig_go = 1'b0;
    logic [15:0]     trig_len = 16'h0;
    logic [2:0]      color_out_o;
    lbft_flash_out_t flash_o;
    logic [31:0]     rd;
    logic            er;
    int              err_count = 0;
    int              n_compared = 0;
    int              cnt[3];
    int pm[16] = '{0, 10, 25, 50, 75, 100, 150, 200, 300, 400, 500, 600,
                   700, 800, 900, 1000};
    int per[8] = '{100, 250, 500, 1000, 2000, 3000, 4000, 5000};
    int fd[3] = '{200, 400, 600};
    logic [7:0] ra[9] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                          8'h40, 8'h44, 8'h48};
    logic [7:0] rm[9] = '{8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f,
                          8'hef, 8'h08, 8'h3f};
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    lbft_core #(.TB_PER_TICK(5)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .sync_pin_i(sync_pin_i), .flash_trigger_i(flash_trigger_i),
        .color_out_o(color_out_o), .flash_o(flash_o)
    );
    lbft_pins_model i_pins (
        .clk_i(clk_i), .sync_run_i(sync_run), .trig_go_i(trig_go),
        .trig_len_i(trig_len), .sync_pin_o(sync_pin_i),
        .trig_o(flash_trigger_i)
    );
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task fail_wait;
        err_count++;
        $display("mismatch at %0t: wait expired", $time);
        end_of_test();
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d,
            input logic s0);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= {3'h0, s0};
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (!(ack_o | err_o) && n < 20);
        if (n >= 20) fail_wait();
        rd = dat_o;
        er = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 1'b1);
    endtask
    task rdchk(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, 1'b1);
        check(rd, {24'h0, e});
    endtask
    task count(input int w);
        cnt = '{0, 0, 0};
        repeat (w) begin
            @(posedge clk_i);
            for (int i = 0; i < 3; i++) cnt[i] += color_out_o[i];
        end
    endtask
    // The pin must be seen low first, otherwise no new rising edge exists.
    task pulse(input int n);
        int m;
        m = 0;
        while (flash_trigger_i !== 1'b0 && m < 20000) begin
            @(posedge clk_i);
            m++;
        end
        if (m >= 20000) fail_wait();
        repeat (5) @(posedge clk_i);
        trig_len <= 16'(n);
        trig_go <= 1'b1;
        @(posedge clk_i);
        trig_go <= 1'b0;
    endtask
    task fire(input int n, input int lo, input int hi);
        int m;
        m = 0;
        pulse(n);
        while (flash_o.full !== 1'b1 && m < 100) begin
            @(posedge clk_i);
            m++;
        end
        if (m >= 100) fail_wait();
        m = 0;
        while (flash_o.full === 1'b1 && m < 40000) begin
            @(posedge clk_i);
            m++;
        end
        check(32'(m >= lo && m <= hi), 32'h1);
    endtask
    task nofire;
        logic s;
        s = 1'b0;
        pulse(500);
        repeat (520) begin
            @(posedge clk_i);
            s = s | flash_o.full;
        end
        check(s, 1'b0);
    endtask
    initial begin
        int v, ron, roff, rp, w, e, cur;
        void'($urandom(32'h4d87));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ra[i]) rdchk(ra[i], 8'h00);
        rdchk(8'h4c, 8'h10);
        foreach (ra[i]) begin
            v = $urandom & rm[i];
            wr(ra[i], 8'(v));
            rdchk(ra[i], 8'(v));
        end
        wb(1'b1, 8'h48, 8'h15, 1'b0);
        rdchk(8'h48, 8'(v));
        wb(1'b0, 8'h80, 8'h00, 1'b1);
        check(er, 1'b1);
        wb(1'b1, 8'h05, 8'hff, 1'b1);
        check(er, 1'b1);
        foreach (ra[i]) wr(ra[i], 8'h00);
        $display("register tests done");
        ron = $urandom % 16;
        roff = $urandom % 16;
        rp = $urandom % 2;
        wr(8'h04, {4'(ron), 4'(roff)});
        wr(8'h08, 8'h08 | 8'(rp));
        wr(8'h0c, 8'hfa);
        wr(8'h10, 8'h08);
        wr(8'h14, 8'h55);
        wr(8'h48, 8'h0f);
        wr(8'h44, 8'h08);
        repeat (200) @(posedge clk_i);
        check(color_out_o[1], 1'b0);
        repeat (500) @(posedge clk_i);
        check(color_out_o[1], 1'b1);
        w = per[rp] * 20;
        count(w);
        v = pm[ron] < 1000 - pm[roff] ? pm[ron] : 1000 - pm[roff];
        e = 2 * v * per[rp] / 100;
        check(32'(cnt[0] >= e - 40 && cnt[0] <= e + 40), 32'h1);
        check(32'(cnt[1] >= w / 2 - 40 && cnt[1] <= w / 2 + 40), 1);
        check(cnt[2], w);
        wr(8'h44, 8'h00);
        repeat (5) @(posedge clk_i);
        check(color_out_o, 3'b111);
        wr(8'h48, 8'h0d);
        repeat (5) @(posedge clk_i);
        check(color_out_o, 3'b101);
        wr(8'h48, 8'h07);
        wr(8'h44, 8'h08);
        repeat (200) @(posedge clk_i);
        check(color_out_o, 3'b111);
        wr(8'h44, 8'h00);
        $display("blink tests done");
        nofire();
        check(flash_o, 5'h00);
        wr(8'h40, 8'h01);
        repeat (2) @(posedge clk_i);
        check(flash_o.on, 1'b1);
        wr(8'h40, 8'h00);
        repeat (2) @(posedge clk_i);
        check(flash_o.on, 1'b0);
        for (int d = 0; d < 3; d++) begin
            cur = $urandom % 4;
            wr(8'h40, {2'(cur), d == 1, 1'b0, 2'(d), 2'b01});
            repeat (3) @(posedge clk_i);
            check(flash_o, {2'(cur), 2'b10, d == 1});
            fire(fd[d] * 10 + 1000, fd[d] * 10 - 12, fd[d] * 10 + 12);
            check(flash_o.on, 1'b0);
            nofire();
            wr(8'h40, 8'h00);
        end
        wr(8'h40, 8'h0d);
        fire(1500, 1490, 1510);
        wr(8'h40, 8'h00);
        wr(8'h40, 8'h0f);
        fire(15000, 11988, 12012);
        wr(8'h40, 8'h00);
        sync_run <= 1'b1;
        wr(8'h48, 8'h20);
        wr(8'h40, 8'h01);
        fire(10000, 8640, 8840);
        sync_run <= 1'b0;
        $display("flash tests done");
        end_of_test();
    end
endmodule // led_blink_and_flash_timing_test
